// *** rtl/elt_defines.vh ***
`ifndef ELT_DEFINES_VH
`define ELT_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define ELT_OFF_OP 8'h00
`define ELT_OFF_ENCL 8'h04
`define ELT_OFF_PAGE 8'h08
`define ELT_OFF_LIN 8'h0c
`define ELT_OFF_DATA 8'h10
`define ELT_OFF_STAT 8'h14
`define ELT_OFF_RDAT 8'h18
`define ELT_OFF_CFG 8'h1c

////////////////////////////////////////////////////////////////////////////////
// operation codes
`define ELT_OP_CREATE 4'h1
`define ELT_OP_ADD 4'h2
`define ELT_OP_EXTEND 4'h3
`define ELT_OP_INIT 4'h4
`define ELT_OP_ENTER 4'h5
`define ELT_OP_EXIT 4'h6
`define ELT_OP_REMOVE 4'h7
`define ELT_OP_FLAGS_WR 4'h8
`define ELT_OP_FLAGS_RD 4'h9
`define ELT_OP_AUG 4'ha
`define ELT_OP_CHECK 4'hb
`define ELT_OP_MEAS_RD 4'hc

////////////////////////////////////////////////////////////////////////////////
// result codes
`define ELT_RES_OK 3'h0
`define ELT_RES_BADOP 3'h1
`define ELT_RES_STATE 3'h2
`define ELT_RES_LOCKED 3'h3
`define ELT_RES_DENIED 3'h4
`define ELT_RES_RANGE 3'h5
`define ELT_RES_PAGE 3'h6

////////////////////////////////////////////////////////////////////////////////
// fields, bit positions, constants
`define ELT_PAGE_SHIFT 12
`define ELT_CFG_EXT 0
`define ELT_CFG_DBG 1
`define ELT_FLAG_OPTIN 0
`define ELT_ST_BUSY 0
`define ELT_ST_RES 1
`define ELT_ST_IN 4
`define ELT_ST_STEP 5
`define ELT_ST_ID 8
`define ELT_MEAS_INIT 32'h5a5a0001
`define ELT_MEAS_MIX 32'h9e3779b9
`define ELT_MEAS_ROT 5
`define ELT_RESP_OKAY 2'h0
`define ELT_RESP_SLVERR 2'h2

`endif

// *** rtl/elt_mem.v ***
`timescale 1ns/1ps
`include "elt_defines.vh"

// page owner table: owner id and thread-structure flag per page
module elt_mem #(
   parameter DEPTH = 16,
   parameter AW = 4,
   parameter DW = 3
)(
   // clock
   input wire mclk,
   // write port
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   // read port, data one cycle after address
   input wire [AW-1:0] raddr,
   output reg [DW-1:0] rdata
);

   reg [DW-1:0] mem [0:DEPTH-1];

   always @(posedge mclk)
   begin
      if (we)
         mem[waddr] <= wdata;
      rdata <= mem[raddr];
   end

endmodule

// *** rtl/elt_measure.v ***
`timescale 1ns/1ps
`include "elt_defines.vh"

// one step of the running build digest; not cryptographic, a stand-in mixer
module elt_measure (
   // digest in and item folded in
   input wire [31:0] cur,
   input wire [31:0] item,
   // digest out
   output wire [31:0] next_meas
);

   wire [31:0] rot;

   assign rot = {cur[31-`ELT_MEAS_ROT:0], cur[31:32-`ELT_MEAS_ROT]};
   assign next_meas = (rot ^ item) + `ELT_MEAS_MIX;

endmodule

// *** rtl/elt_top.v ***
// How it works
// - one hidden control structure per enclave
// - create sets up structure, seeds measurement
// - add page and extend update measurement
// - initialize locks measurement for good
// - thread structures per enclave for entry/exit
// - flags access only for debug enclaves
// - debug opt-in bit permits single stepping
// - thread structure made by add or extended ops
// - enter transfers to enclave code, exit returns
// - range reserves addresses; commit attaches pages
// - removed page is free for others
// - outside software blocked from enclave pages
// - extended ops add memory to running enclave
// - pages are 4KB, 4KB aligned
`timescale 1ns/1ps
`include "elt_defines.vh"

module elt_top #(
   parameter NENC = 4,
   parameter IDW = 2,
   parameter NPAGE = 16,
   parameter PW = 4
)(
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // axi4-lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // execution context
   output reg in_enclave,
   output reg step_permit
);

   localparam S_IDLE = 2'b01;
   localparam S_EXEC = 2'b10;

   ////////////////////////////////////////////////////////////////////////////////
   // declarations

   reg [1:0] state;
   reg [3:0] op_arg;
   reg [IDW-1:0] id_arg;
   reg [PW-1:0] page_arg;
   reg [31:0] lin_arg;
   reg [31:0] data_arg;
   reg [1:0] cfg;
   reg [2:0] result;
   reg [31:0] rdat;
   reg start;

   reg aw_held;
   reg [7:0] aw_addr;
   reg w_held;
   reg [31:0] w_data;
   reg [3:0] w_strb;

   reg [NENC-1:0] e_valid;
   reg [NENC-1:0] e_locked;
   reg [NENC-1:0] e_debug;
   reg [31:0] e_meas [0:NENC-1];
   reg [19:0] e_base [0:NENC-1];
   reg [19:0] e_size [0:NENC-1];
   reg [3:0] e_tcs_cnt [0:NENC-1];
   reg [31:0] e_flags [0:NENC-1];
   reg [NPAGE-1:0] pg_valid;
   reg [IDW-1:0] cur_id;

   reg [31:0] next_rdata;
   reg [1:0] next_rresp;

   wire [IDW:0] m_rdata;
   wire [IDW-1:0] m_owner;
   wire m_tcs;
   wire busy;
   wire do_wr;
   wire ev;
   wire el;
   wire ed;
   wire has_tcs;
   wire pvalid;
   wire owned;
   wire mine_now;
   wire [19:0] lp;
   wire [19:0] off;
   wire aligned;
   wire in_rng;
   wire place_ok;
   wire commit;
   wire [31:0] meas_item;
   wire [31:0] meas_new;
   integer i;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] st;
      integer k;
      begin
         for (k = 0; k < 4; k = k + 1)
            merge[k*8 +: 8] = st[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // operation checks

   assign busy = state[1];
   assign do_wr = aw_held & w_held & ~s_axi_bvalid;
   assign m_owner = m_rdata[IDW-1:0];
   assign m_tcs = m_rdata[IDW];
   assign ev = e_valid[id_arg];
   assign el = e_locked[id_arg];
   assign ed = e_debug[id_arg];
   assign has_tcs = e_tcs_cnt[id_arg] != 4'h0;
   assign pvalid = pg_valid[page_arg];
   assign owned = pvalid & (m_owner == id_arg);
   assign mine_now = in_enclave & (cur_id == m_owner);
   assign lp = lin_arg[31:`ELT_PAGE_SHIFT];
   assign aligned = lin_arg[`ELT_PAGE_SHIFT-1:0] == {`ELT_PAGE_SHIFT{1'b0}};
   assign off = lp - e_base[id_arg];
   assign in_rng = (lp >= e_base[id_arg]) & (off < e_size[id_arg]);
   assign place_ok = aligned & in_rng & ~pvalid;
   // commitment is the only path that attaches a page to an enclave
   assign commit = busy & place_ok & ev &
      (((op_arg == `ELT_OP_ADD) & ~el) |
       ((op_arg == `ELT_OP_AUG) & el & cfg[`ELT_CFG_EXT]));
   assign meas_item = (op_arg == `ELT_OP_EXTEND) ? data_arg : lin_arg;

   elt_mem #(
      .DEPTH(NPAGE),
      .AW(PW),
      .DW(IDW + 1)
   ) u_mem (
      .mclk(mclk),
      .we(commit),
      .waddr(page_arg),
      .wdata({data_arg[0], id_arg}),
      .raddr(page_arg),
      .rdata(m_rdata)
   );

   elt_measure u_meas (
      .cur(e_meas[id_arg]),
      .item(meas_item),
      .next_meas(meas_new)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite write side and argument registers

   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ELT_RESP_OKAY;
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         op_arg <= 4'h0;
         id_arg <= {IDW{1'b0}};
         page_arg <= {PW{1'b0}};
         lin_arg <= 32'h0000_0000;
         data_arg <= 32'h0000_0000;
         cfg <= 2'h0;
         start <= 1'b0;
      end
      else
      begin
         start <= 1'b0;
         if (s_axi_awvalid & s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_wr)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `ELT_RESP_OKAY;
            case (aw_addr)
               `ELT_OFF_OP:
                  // a new operation while one runs is refused, not queued
                  if (busy | start)
                     s_axi_bresp <= `ELT_RESP_SLVERR;
                  else if (w_strb[0])
                  begin
                     op_arg <= w_data[3:0];
                     start <= 1'b1;
                  end
               `ELT_OFF_ENCL:
                  if (w_strb[0])
                     id_arg <= w_data[IDW-1:0];
               `ELT_OFF_PAGE:
                  if (w_strb[0])
                     page_arg <= w_data[PW-1:0];
               `ELT_OFF_LIN:
                  lin_arg <= merge(lin_arg, w_data, w_strb);
               `ELT_OFF_DATA:
                  data_arg <= merge(data_arg, w_data, w_strb);
               `ELT_OFF_CFG:
                  if (w_strb[0])
                     cfg <= w_data[1:0];
               `ELT_OFF_STAT, `ELT_OFF_RDAT:
                  s_axi_bresp <= `ELT_RESP_OKAY;
               default:
                  s_axi_bresp <= `ELT_RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid & s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite read side; control structures have no address of their own

   always @*
   begin
      next_rresp = `ELT_RESP_OKAY;
      next_rdata = 32'h0000_0000;
      case (s_axi_araddr)
         `ELT_OFF_OP: next_rdata[3:0] = op_arg;
         `ELT_OFF_ENCL: next_rdata[IDW-1:0] = id_arg;
         `ELT_OFF_PAGE: next_rdata[PW-1:0] = page_arg;
         `ELT_OFF_LIN: next_rdata = lin_arg;
         `ELT_OFF_DATA: next_rdata = data_arg;
         `ELT_OFF_STAT:
         begin
            next_rdata[`ELT_ST_BUSY] = busy | start;
            next_rdata[`ELT_ST_RES +: 3] = result;
            next_rdata[`ELT_ST_IN] = in_enclave;
            next_rdata[`ELT_ST_STEP] = step_permit;
            next_rdata[`ELT_ST_ID +: IDW] = cur_id;
         end
         `ELT_OFF_RDAT: next_rdata = rdat;
         `ELT_OFF_CFG: next_rdata[1:0] = cfg;
         default: next_rresp = `ELT_RESP_SLVERR;
      endcase
   end

   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `ELT_RESP_OKAY;
      end
      else
      begin
         if (s_axi_arvalid & s_axi_arready)
         begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
         end
         if (s_axi_rvalid & s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // operation engine: one execute cycle per operation

   always @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= S_IDLE;
         result <= `ELT_RES_OK;
         rdat <= 32'h0000_0000;
         e_valid <= {NENC{1'b0}};
         e_locked <= {NENC{1'b0}};
         e_debug <= {NENC{1'b0}};
         pg_valid <= {NPAGE{1'b0}};
         in_enclave <= 1'b0;
         cur_id <= {IDW{1'b0}};
         step_permit <= 1'b0;
         for (i = 0; i < NENC; i = i + 1)
         begin
            e_meas[i] <= 32'h0000_0000;
            e_base[i] <= 20'h00000;
            e_size[i] <= 20'h00000;
            e_tcs_cnt[i] <= 4'h0;
            e_flags[i] <= 32'h0000_0000;
         end
      end
      else
      begin
         // stepping is allowed only inside a debug enclave that opted in
         step_permit <= in_enclave & e_debug[cur_id] &
            e_flags[cur_id][`ELT_FLAG_OPTIN];
         case (state)
            S_IDLE:
               if (start)
                  state <= S_EXEC;
            S_EXEC:
            begin
               state <= S_IDLE;
               result <= `ELT_RES_OK;
               case (op_arg)
                  `ELT_OP_CREATE:
                     if (ev)
                        result <= `ELT_RES_STATE;
                     else
                     begin
                        e_valid[id_arg] <= 1'b1;
                        e_locked[id_arg] <= 1'b0;
                        e_debug[id_arg] <= cfg[`ELT_CFG_DBG];
                        e_meas[id_arg] <= `ELT_MEAS_INIT;
                        e_base[id_arg] <= lp;
                        e_size[id_arg] <= data_arg[19:0];
                        e_tcs_cnt[id_arg] <= 4'h0;
                        e_flags[id_arg] <= 32'h0000_0000;
                     end
                  `ELT_OP_ADD, `ELT_OP_AUG:
                     if (op_arg == `ELT_OP_AUG & ~cfg[`ELT_CFG_EXT])
                        result <= `ELT_RES_BADOP;
                     else if (~ev | (op_arg == `ELT_OP_AUG & ~el))
                        result <= `ELT_RES_STATE;
                     else if (op_arg == `ELT_OP_ADD & el)
                        result <= `ELT_RES_LOCKED;
                     else if (~aligned | ~in_rng)
                        result <= `ELT_RES_RANGE;
                     else if (pvalid)
                        result <= `ELT_RES_PAGE;
                     else
                     begin
                        pg_valid[page_arg] <= 1'b1;
                        if (op_arg == `ELT_OP_ADD)
                           e_meas[id_arg] <= meas_new;
                        if (data_arg[0])
                           e_tcs_cnt[id_arg] <= e_tcs_cnt[id_arg] + 4'h1;
                     end
                  `ELT_OP_EXTEND:
                     if (~ev)
                        result <= `ELT_RES_STATE;
                     else if (el)
                        result <= `ELT_RES_LOCKED;
                     else if (~owned)
                        result <= `ELT_RES_PAGE;
                     else
                        e_meas[id_arg] <= meas_new;
                  `ELT_OP_INIT:
                     if (~ev)
                        result <= `ELT_RES_STATE;
                     else if (el)
                        result <= `ELT_RES_LOCKED;
                     else
                        e_locked[id_arg] <= 1'b1;
                  `ELT_OP_ENTER:
                     if (~ev | ~el | in_enclave | ~has_tcs)
                        result <= `ELT_RES_STATE;
                     else if (~owned)
                        result <= `ELT_RES_PAGE;
                     else
                     begin
                        in_enclave <= 1'b1;
                        cur_id <= id_arg;
                     end
                  `ELT_OP_EXIT:
                     if (~in_enclave)
                        result <= `ELT_RES_STATE;
                     else
                        in_enclave <= 1'b0;
                  `ELT_OP_REMOVE:
                     // teardown relies on software sweeping every page
                     if (~pvalid)
                        result <= `ELT_RES_PAGE;
                     else if (mine_now)
                        result <= `ELT_RES_STATE;
                     else
                     begin
                        pg_valid[page_arg] <= 1'b0;
                        if (m_tcs & e_tcs_cnt[m_owner] != 4'h0)
                           e_tcs_cnt[m_owner] <= e_tcs_cnt[m_owner] - 4'h1;
                     end
                  `ELT_OP_FLAGS_WR:
                     if (~ev | ~ed | ~has_tcs)
                        result <= `ELT_RES_DENIED;
                     else
                        e_flags[id_arg] <= data_arg;
                  `ELT_OP_FLAGS_RD:
                     if (~ev | ~ed | ~has_tcs)
                        result <= `ELT_RES_DENIED;
                     else
                        rdat <= e_flags[id_arg];
                  `ELT_OP_CHECK:
                     if (pvalid & ~mine_now)
                        result <= `ELT_RES_DENIED;
                  `ELT_OP_MEAS_RD:
                     if (~ev | ~el)
                        result <= `ELT_RES_DENIED;
                     else
                        rdat <= e_meas[id_arg];
                  default:
                     result <= `ELT_RES_BADOP;
               endcase
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end

endmodule

// *** bench/elt_checker.sv ***
`timescale 1ns/1ps
`include "elt_defines.vh"

module elt_checker (
   // clock and reset
   input wire mclk,
   input wire reset_n,
   // write channels
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   // read channels
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // execution context
   input wire in_enclave,
   input wire step_permit
);
////////////////////////////////////////////////////////////////////////////////
default clocking @(posedge mclk); endclocking
default disable iff (!reset_n);

property p_b_hold;
   s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
endproperty
a_b_hold: assert property (p_b_hold) else $error("write response dropped early");

property p_b_time;
   s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
endproperty
a_b_time: assert property (p_b_time) else $error("write response not two cycles after take");

property p_b_ready;
   s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
endproperty
a_b_ready: assert property (p_b_ready) else $error("write ready high during response");

property p_r_time;
   s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
endproperty
a_r_time: assert property (p_r_time) else $error("read data not one cycle after take");

property p_r_hold;
   s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
endproperty
a_r_hold: assert property (p_r_hold) else $error("read data dropped early");

property p_r_unmap;
   s_axi_arvalid && s_axi_arready && s_axi_araddr[7:5] != 3'h0
      |=> s_axi_rresp == `ELT_RESP_SLVERR && s_axi_rdata == 32'h0;
endproperty
a_r_unmap: assert property (p_r_unmap) else $error("unmapped read not refused");

property p_step_lag;
   $rose(step_permit) |-> $past(in_enclave) && in_enclave;
endproperty
a_step_lag: assert property (p_step_lag) else $error("step permit without entry");

property p_step_drop;
   $fell(in_enclave) |=> !step_permit;
endproperty
a_step_drop: assert property (p_step_drop) else $error("step permit kept after exit");

c_enter: cover property ($rose(in_enclave));
c_step: cover property ($rose(step_permit));
c_err: cover property (s_axi_bvalid && s_axi_bresp == `ELT_RESP_SLVERR);
endmodule

bind elt_top elt_checker u_chk (.*);

// *** bench/elt_test.sv ***
`timescale 1ns/1ps
`include "elt_defines.vh"

module elt_test;
logic mclk, reset_n;
logic [7:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [3:0] s_axi_wstrb;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, in_enclave, step_permit;
int n_mismatch, n_compared, i;
logic [15:0] seed;
logic [31:0] meas, rv, d;
logic [1:0] rr;
localparam [31:0] BASE = 32'h00010000;
localparam [31:0] BASE2 = 32'h00020000;

elt_top uut (.*);

initial
begin
   mclk = 1'b0;
   forever #2 mclk = ~mclk;
end
////////////////////////////////////////////////////////////////////////////////
function [15:0] lfsr(input [15:0] v);
   lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
endfunction

// running digest step, same shape as the block's measurement update
function [31:0] mix(input [31:0] m, input [31:0] item);
   mix = ({m[26:0], m[31:27]} ^ item) + `ELT_MEAS_MIX;
endfunction

task chk(input string what, input [31:0] seen, input [31:0] exp);
   n_compared++;
   if (seen !== exp)
   begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
   end
endtask

task wr(input [7:0] a, input [31:0] dv, input [1:0] er);
   @(posedge mclk);
   s_axi_awaddr <= a;
   s_axi_wdata <= dv;
   s_axi_awvalid <= 1'b1;
   s_axi_wvalid <= 1'b1;
   s_axi_bready <= 1'b1;
   do
   begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
   end
   while (!s_axi_bvalid);
   s_axi_bready <= 1'b0;
   chk("bresp", {s_axi_bvalid, s_axi_bresp}, {1'b1, er});
endtask

task rd(input [7:0] a, output [31:0] dv, output [1:0] r);
   @(posedge mclk);
   s_axi_araddr <= a;
   s_axi_arvalid <= 1'b1;
   s_axi_rready <= 1'b1;
   do
   begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
   end
   while (!s_axi_rvalid);
   s_axi_rready <= 1'b0;
   dv = s_axi_rdata;
   r = s_axi_rresp;
   chk("rvalid", s_axi_rvalid, 1);
endtask

// load arguments, start, then poll busy; the result field is compared
// reference model of enclave and page state, written from the operation checks
int mv[4], ml[4], md[4], mb[4], ms[4], mt[4], mpv[16], mpo[16], mpt[16];
int m_in, m_cur, mcfg;

function automatic int model(input int c, id, pg, lin, dv);
   int lp, rng, own;
   lp = lin >> `ELT_PAGE_SHIFT;
   rng = lin % (1 << `ELT_PAGE_SHIFT) == 0 && lp >= mb[id] && lp - mb[id] < ms[id];
   own = mpv[pg] && mpo[pg] == id;
   model = `ELT_RES_OK;
   case (c)
      `ELT_OP_CREATE:
         if (mv[id]) model = `ELT_RES_STATE;
         else
         begin
            mv[id] = 1;
            ml[id] = 0;
            md[id] = mcfg / 2 % 2;
            mb[id] = lp;
            ms[id] = dv & 32'h000f_ffff;
            mt[id] = 0;
         end
      `ELT_OP_ADD, `ELT_OP_AUG:
         if (c == `ELT_OP_AUG && mcfg % 2 == 0) model = `ELT_RES_BADOP;
         else if (!mv[id] || (c == `ELT_OP_AUG && !ml[id])) model = `ELT_RES_STATE;
         else if (c == `ELT_OP_ADD && ml[id]) model = `ELT_RES_LOCKED;
         else if (!rng) model = `ELT_RES_RANGE;
         else if (mpv[pg]) model = `ELT_RES_PAGE;
         else
         begin
            mpv[pg] = 1;
            mpo[pg] = id;
            mpt[pg] = dv & 1;
            mt[id] += dv & 1;
         end
      `ELT_OP_EXTEND:
         if (!mv[id]) model = `ELT_RES_STATE;
         else if (ml[id]) model = `ELT_RES_LOCKED;
         else if (!own) model = `ELT_RES_PAGE;
      `ELT_OP_INIT:
         if (!mv[id]) model = `ELT_RES_STATE;
         else if (ml[id]) model = `ELT_RES_LOCKED;
         else ml[id] = 1;
      `ELT_OP_ENTER:
         if (!mv[id] || !ml[id] || m_in || !mt[id]) model = `ELT_RES_STATE;
         else if (!own) model = `ELT_RES_PAGE;
         else
         begin
            m_in = 1;
            m_cur = id;
         end
      `ELT_OP_EXIT:
         if (!m_in) model = `ELT_RES_STATE;
         else m_in = 0;
      `ELT_OP_REMOVE:
         if (!mpv[pg]) model = `ELT_RES_PAGE;
         else if (m_in && m_cur == mpo[pg]) model = `ELT_RES_STATE;
         else
         begin
            mpv[pg] = 0;
            if (mpt[pg] && mt[mpo[pg]]) mt[mpo[pg]]--;
         end
      `ELT_OP_FLAGS_WR, `ELT_OP_FLAGS_RD:
         if (!mv[id] || !md[id] || !mt[id]) model = `ELT_RES_DENIED;
      `ELT_OP_CHECK:
         if (mpv[pg] && !(m_in && m_cur == mpo[pg])) model = `ELT_RES_DENIED;
      `ELT_OP_MEAS_RD:
         if (!mv[id] || !ml[id]) model = `ELT_RES_DENIED;
      default: model = `ELT_RES_BADOP;
   endcase
endfunction

task do_op(input [3:0] c, input [31:0] id, pg, lin, dv, input [2:0] ex);
   wr(`ELT_OFF_ENCL, id, `ELT_RESP_OKAY);
   wr(`ELT_OFF_PAGE, pg, `ELT_RESP_OKAY);
   wr(`ELT_OFF_LIN, lin, `ELT_RESP_OKAY);
   wr(`ELT_OFF_DATA, dv, `ELT_RESP_OKAY);
   wr(`ELT_OFF_OP, {28'h0, c}, `ELT_RESP_OKAY);
   do
   begin
      rd(`ELT_OFF_STAT, rv, rr);
   end
   while (rv[`ELT_ST_BUSY]);
   chk("result", rv[3:1], ex);
   chk("model", rv[3:1], model(c, id, pg, lin, dv));
endtask

task tdone(input string s);
   $display("test %s done", s);
endtask

task wrap_up;
   $display("compared %0d mismatches %0d", n_compared, n_mismatch);
   if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
   else
      $display("== FAILED ==");
   $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
// about fourteen times the expected run of some 900 cycles
initial
begin
   #50000;
   n_mismatch++;
   wrap_up;
end

initial
begin
   {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
   {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
   s_axi_wstrb = 4'hf;
   reset_n = 1'b0;
   seed = 16'h8cf0;
   n_mismatch = 0;
   n_compared = 0;
   repeat (20) @(posedge mclk);
   reset_n <= 1'b1;
   rd(`ELT_OFF_STAT, rv, rr);
   chk("status", rv, 32'h0);
   rd(8'h20, rv, rr);
   chk("unmapped resp", rr, `ELT_RESP_SLVERR);
   chk("unmapped data", rv, 32'h0);
   wr(8'h24, 32'h1, `ELT_RESP_SLVERR);
   tdone("reset");
   mcfg = 3;
   wr(`ELT_OFF_CFG, 32'h3, `ELT_RESP_OKAY);
   meas = `ELT_MEAS_INIT;
   do_op(`ELT_OP_CREATE, 0, 0, BASE, 8, `ELT_RES_OK);
   do_op(`ELT_OP_MEAS_RD, 0, 0, 0, 0, `ELT_RES_DENIED);
   do_op(`ELT_OP_ADD, 0, 0, BASE, 1, `ELT_RES_OK);
   meas = mix(meas, BASE);
   do_op(`ELT_OP_ADD, 0, 1, BASE + 32'h1001, 0, `ELT_RES_RANGE);
   do_op(`ELT_OP_ADD, 0, 1, BASE + 32'h8000, 0, `ELT_RES_RANGE);
   do_op(`ELT_OP_ADD, 0, 0, BASE + 32'h1000, 0, `ELT_RES_PAGE);
   do_op(`ELT_OP_EXTEND, 0, 1, 0, 0, `ELT_RES_PAGE);
   for (i = 0; i < 4; i++)
   begin
      seed = lfsr(seed);
      d = {seed, ~seed};
      do_op(`ELT_OP_EXTEND, 0, 0, 0, d, `ELT_RES_OK);
      meas = mix(meas, d);
   end
   do_op(`ELT_OP_INIT, 0, 0, 0, 0, `ELT_RES_OK);
   do_op(`ELT_OP_INIT, 0, 0, 0, 0, `ELT_RES_LOCKED);
   do_op(`ELT_OP_ADD, 0, 3, BASE + 32'h3000, 0, `ELT_RES_LOCKED);
   do_op(`ELT_OP_EXTEND, 0, 0, 0, d, `ELT_RES_LOCKED);
   do_op(`ELT_OP_MEAS_RD, 0, 0, 0, 0, `ELT_RES_OK);
   rd(`ELT_OFF_RDAT, rv, rr);
   chk("measurement", rv, meas);
   tdone("build");
   do_op(`ELT_OP_FLAGS_WR, 0, 0, 0, 1, `ELT_RES_OK);
   do_op(`ELT_OP_FLAGS_RD, 0, 0, 0, 0, `ELT_RES_OK);
   rd(`ELT_OFF_RDAT, rv, rr);
   chk("flags", rv, 32'h1);
   do_op(`ELT_OP_ENTER, 0, 0, 0, 0, `ELT_RES_OK);
   rd(`ELT_OFF_STAT, rv, rr);
   chk("context", {in_enclave, step_permit, rv[5:4]}, 4'hf);
   do_op(`ELT_OP_CHECK, 0, 0, 0, 0, `ELT_RES_OK);
   do_op(`ELT_OP_REMOVE, 0, 0, 0, 0, `ELT_RES_STATE);
   do_op(`ELT_OP_ENTER, 0, 0, 0, 0, `ELT_RES_STATE);
   do_op(`ELT_OP_EXIT, 0, 0, 0, 0, `ELT_RES_OK);
   chk("in_enclave", in_enclave, 0);
   do_op(`ELT_OP_EXIT, 0, 0, 0, 0, `ELT_RES_STATE);
   do_op(`ELT_OP_CHECK, 0, 0, 0, 0, `ELT_RES_DENIED);
   tdone("entry");
   mcfg = 1;
   wr(`ELT_OFF_CFG, 32'h1, `ELT_RESP_OKAY);
   do_op(`ELT_OP_CREATE, 1, 0, BASE2, 4, `ELT_RES_OK);
   do_op(`ELT_OP_FLAGS_RD, 1, 0, 0, 0, `ELT_RES_DENIED);
   do_op(`ELT_OP_AUG, 0, 2, BASE + 32'h2000, 1, `ELT_RES_OK);
   do_op(`ELT_OP_MEAS_RD, 0, 0, 0, 0, `ELT_RES_OK);
   rd(`ELT_OFF_RDAT, rv, rr);
   chk("measurement", rv, meas);
   do_op(`ELT_OP_REMOVE, 0, 0, 0, 0, `ELT_RES_OK);
   do_op(`ELT_OP_REMOVE, 0, 0, 0, 0, `ELT_RES_PAGE);
   do_op(`ELT_OP_ADD, 1, 0, BASE2, 0, `ELT_RES_OK);
   do_op(`ELT_OP_REMOVE, 0, 2, 0, 0, `ELT_RES_OK);
   do_op(`ELT_OP_ENTER, 0, 2, 0, 0, `ELT_RES_STATE);
   mcfg = 0;
   wr(`ELT_OFF_CFG, 32'h0, `ELT_RESP_OKAY);
   do_op(`ELT_OP_AUG, 0, 4, BASE + 32'h4000, 0, `ELT_RES_BADOP);
   do_op(4'hf, 0, 0, 0, 0, `ELT_RES_BADOP);
   tdone("reclaim");
   s_axi_wstrb <= 4'h3;
   wr(`ELT_OFF_LIN, 32'hffff_ffff, `ELT_RESP_OKAY);
   s_axi_wstrb <= 4'hf;
   rd(`ELT_OFF_LIN, rv, rr);
   chk("lin strobes", rv, 32'h0000_ffff);
   tdone("strobes");
   wrap_up;
end
endmodule
